/* File: verilog/sswd_pkg.sv */
// Function
// [R01] one shared watchdog tick feeds both watchdogs, made by dividing the base clock
// [R02] a watchdog tick lasts multiplier plus two base ticks of 40 ns
// [R03] multiplier resets to 2498, giving a 100 us watchdog tick
// [R04] output watchdog time resets to 1000 ticks, 100 ms
// [R05] output watchdog time takes 0..65535, multiplier takes 1..65535
// [R06] set outputs are cleared when output traffic stops for the programmed time
// [R07] output watchdog time of zero disables the watchdog and output clearing
// [R08] five slave states: init, pre-op, safe-op, op and boot
// [R09] reset enters init, with mailbox and process data both blocked
// [R10] master sets up mailbox channels 0 and 1 while in init
// [R11] init to pre-op needs a correct mailbox setup
// [R12] pre-op allows mailbox only; master sets up process data from channel 2
// [R13] entering safe-op checks process data and clock setup, captures inputs
// [R14] safe-op allows all traffic, refreshes inputs, holds outputs safe
// [R15] with the output watchdog off, outputs switch in safe-op too
// [R16] master delivers valid output data before asking for op
// [R17] op drives the outputs from received output data, all traffic allowed
// [R18] boot only from init; only file-access mailbox, no process data
// [R19] master writes multiplier and watchdog times at 0x400, 0x410, 0x420
// [R20] each completed output data write reloads the output watchdog
package sswd_pkg;

  // ----------------------------------------------------------------
  // base tick generation
  // ----------------------------------------------------------------
  localparam logic [6:0]  CLK_PERIOD_NS  = 7'h19;
  localparam logic [6:0]  BASE_TICK_NS   = 7'h28;
  localparam logic [16:0] MULT_EXTRA     = 17'h00002;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 12;
  localparam logic [11:0] OFS_AL_CTRL    = 12'h120;
  localparam logic [11:0] OFS_AL_STAT    = 12'h130;
  localparam logic [11:0] OFS_CFG        = 12'h140;
  localparam logic [11:0] OFS_MULT       = 12'h400;
  localparam logic [11:0] OFS_PDI_WD     = 12'h410;
  localparam logic [11:0] OFS_SM_WD      = 12'h420;
  localparam logic [11:0] OFS_WD_STAT    = 12'h440;
  localparam logic [11:0] OFS_OUT        = 12'hf00;
  localparam logic [11:0] OFS_IN         = 12'hf80;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MULT_RST       = 16'h09c2;
  localparam logic [15:0] PDI_TIME_RST   = 16'h03e8;
  localparam logic [15:0] SM_TIME_RST    = 16'h03e8;

  // ----------------------------------------------------------------
  // field positions and state codes
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MBX_BIT    = 0;
  localparam int unsigned CFG_PD_BIT     = 1;
  localparam int unsigned CFG_DC_BIT     = 2;
  localparam int unsigned STAT_ERR_BIT   = 4;
  localparam int unsigned WD_SM_BIT      = 0;
  localparam int unsigned WD_PDI_BIT     = 1;
  localparam logic [3:0]  CODE_INIT      = 4'h1;
  localparam logic [3:0]  CODE_PREOP     = 4'h2;
  localparam logic [3:0]  CODE_BOOT      = 4'h3;
  localparam logic [3:0]  CODE_SAFEOP    = 4'h4;
  localparam logic [3:0]  CODE_OP        = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_OP,
    ST_BOOT
  } sswd_state_t;

  typedef struct packed {
    logic [15:0] mult;
    logic [15:0] pdi_time;
    logic [15:0] sm_time;
  } sswd_wd_cfg_t;

  typedef struct packed {
    logic mbx_en;
    logic foe_only;
    logic pd_en;
  } sswd_comm_t;

endpackage

/* File: verilog/sswd_wd_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module sswd_wd_counter #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // control
  input  wire logic         tick,
  input  wire logic         reload,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  // status
  output logic              expired
);

  logic [W-1:0] cnt_reg;
  logic         exp_reg;
  logic         armed_reg;

  // ----------------------------------------------------------------
  // countdown in watchdog ticks
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg   <= '0;
      exp_reg   <= 1'b0;
      armed_reg <= 1'b0;
    end
    else if (ce)
    begin
      armed_reg <= 1'b1;
      // first enabled cycle after reset loads the limit
      if (reload || !run || !armed_reg || limit == '0) // see [R07] see [R20]
      begin
        cnt_reg <= limit;
        exp_reg <= 1'b0;
      end
      else if (tick && !exp_reg)
      begin
        if (cnt_reg <= W'(1)) // see [R06]
        begin
          cnt_reg <= '0;
          exp_reg <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg - W'(1);
        end
      end
    end
  end

  assign expired = exp_reg;

endmodule

`default_nettype wire

/* File: verilog/sswd_top.sv */
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sswd_top #(
  parameter int unsigned OUT_W = 16
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // process side
  input  wire logic [OUT_W-1:0]         din,
  input  wire logic                     pdi_kick,
  output logic [OUT_W-1:0]              dout,
  output sswd_pkg::sswd_comm_t          comm,
  output logic                          sm_wd_tripped
);

  sswd_pkg::sswd_state_t  state_reg;
  sswd_pkg::sswd_state_t  state_next;
  sswd_pkg::sswd_state_t  req_state;
  sswd_pkg::sswd_wd_cfg_t wd_cfg_reg;
  sswd_pkg::sswd_comm_t   comm_reg;
  logic [2:0]             cfg_reg;
  logic                   err_reg;
  logic [1:0]             wd_stat_reg;
  logic [OUT_W-1:0]       out_reg;
  logic [OUT_W-1:0]       in_img_reg;
  logic [OUT_W-1:0]       dout_reg;
  logic                   out_valid_reg;
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic [5:0]             acc_reg;
  logic [6:0]             acc_sum;
  logic                   base_tick;
  logic [16:0]            presc_reg;
  logic                   wd_tick_reg;
  logic                   sm_exp;
  logic                   sm_exp_q;
  logic                   pdi_exp;
  logic                   pdi_exp_q;
  logic                   sm_trip;
  logic                   pdi_trip;
  logic                   wr_en;
  logic                   ctrl_wr;
  logic                   out_wr;
  logic                   req_known;
  logic                   req_allow;
  logic                   pd_state;
  logic [31:0]            rd_data;
  logic                   rd_hit;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_en    = ce && psel && penable && pready_reg && pwrite;
  assign ctrl_wr  = wr_en && paddr == sswd_pkg::OFS_AL_CTRL;
  assign pd_state = state_reg == sswd_pkg::ST_SAFEOP || state_reg == sswd_pkg::ST_OP;
  assign out_wr   = wr_en && paddr == sswd_pkg::OFS_OUT && pd_state; // see [R12] see [R18]

  always_comb
  begin
    rd_data = '0;
    rd_hit  = 1'b1;
    unique case (paddr)
      sswd_pkg::OFS_AL_CTRL: rd_data[3:0] = 4'h0;
      sswd_pkg::OFS_AL_STAT:
      begin
        rd_data[sswd_pkg::STAT_ERR_BIT] = err_reg;
        unique case (state_reg)
          sswd_pkg::ST_INIT:   rd_data[3:0] = sswd_pkg::CODE_INIT;
          sswd_pkg::ST_PREOP:  rd_data[3:0] = sswd_pkg::CODE_PREOP;
          sswd_pkg::ST_SAFEOP: rd_data[3:0] = sswd_pkg::CODE_SAFEOP;
          sswd_pkg::ST_OP:     rd_data[3:0] = sswd_pkg::CODE_OP;
          sswd_pkg::ST_BOOT:   rd_data[3:0] = sswd_pkg::CODE_BOOT;
        endcase
      end
      sswd_pkg::OFS_CFG:     rd_data[2:0]       = cfg_reg;
      sswd_pkg::OFS_MULT:    rd_data[15:0]      = wd_cfg_reg.mult;
      sswd_pkg::OFS_PDI_WD:  rd_data[15:0]      = wd_cfg_reg.pdi_time;
      sswd_pkg::OFS_SM_WD:   rd_data[15:0]      = wd_cfg_reg.sm_time;
      sswd_pkg::OFS_WD_STAT: rd_data[1:0]       = wd_stat_reg;
      sswd_pkg::OFS_OUT:     rd_data[OUT_W-1:0] = out_reg;
      sswd_pkg::OFS_IN:      rd_data[OUT_W-1:0] = in_img_reg;
      default:               rd_hit             = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb handshake, one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else if (ce)
    begin
      pready_reg  <= psel && !penable && !pready_reg;
      pslverr_reg <= psel && !penable && !rd_hit;
      if (psel && !penable)
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cfg_reg.mult     <= sswd_pkg::MULT_RST; // see [R03]
      wd_cfg_reg.pdi_time <= sswd_pkg::PDI_TIME_RST;
      wd_cfg_reg.sm_time  <= sswd_pkg::SM_TIME_RST; // see [R04]
      cfg_reg             <= 3'h0;
    end
    else if (wr_en)
    begin
      if (paddr == sswd_pkg::OFS_MULT && pwdata[15:0] != 16'h0000) // see [R05] see [R19]
        wd_cfg_reg.mult <= pwdata[15:0];
      if (paddr == sswd_pkg::OFS_PDI_WD)
        wd_cfg_reg.pdi_time <= pwdata[15:0];
      if (paddr == sswd_pkg::OFS_SM_WD) // see [R05] see [R19]
        wd_cfg_reg.sm_time <= pwdata[15:0];
      if (paddr == sswd_pkg::OFS_CFG)
        cfg_reg <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // slave state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    req_known = 1'b1;
    req_state = sswd_pkg::ST_INIT;
    unique case (pwdata[3:0])
      sswd_pkg::CODE_INIT:   req_state = sswd_pkg::ST_INIT;
      sswd_pkg::CODE_PREOP:  req_state = sswd_pkg::ST_PREOP;
      sswd_pkg::CODE_SAFEOP: req_state = sswd_pkg::ST_SAFEOP;
      sswd_pkg::CODE_OP:     req_state = sswd_pkg::ST_OP;
      sswd_pkg::CODE_BOOT:   req_state = sswd_pkg::ST_BOOT;
      default:               req_known = 1'b0;
    endcase
    req_allow = 1'b0;
    unique case (req_state)
      sswd_pkg::ST_INIT:   req_allow = 1'b1;
      sswd_pkg::ST_PREOP:  req_allow = (state_reg == sswd_pkg::ST_INIT) ?
                                       cfg_reg[sswd_pkg::CFG_MBX_BIT] : // see [R11]
                                       state_reg != sswd_pkg::ST_BOOT;
      sswd_pkg::ST_SAFEOP: req_allow = (state_reg == sswd_pkg::ST_PREOP) ?
                                       cfg_reg[sswd_pkg::CFG_PD_BIT] &&
                                       cfg_reg[sswd_pkg::CFG_DC_BIT] : // see [R13]
                                       pd_state;
      sswd_pkg::ST_OP:     req_allow = (state_reg == sswd_pkg::ST_SAFEOP) ?
                                       out_valid_reg : // see [R16]
                                       state_reg == sswd_pkg::ST_OP;
      sswd_pkg::ST_BOOT:   req_allow = state_reg == sswd_pkg::ST_INIT ||
                                       state_reg == sswd_pkg::ST_BOOT; // see [R18]
    endcase
    req_allow  = req_allow && req_known;
    state_next = (ctrl_wr && req_allow) ? req_state : state_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= sswd_pkg::ST_INIT; // see [R08] see [R09]
    else if (ce)
      state_reg <= state_next;
  end

  // refused request flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_reg <= 1'b0;
    else if (ctrl_wr && !req_allow)
      err_reg <= 1'b1;
    else if (wr_en && paddr == sswd_pkg::OFS_AL_STAT && pwdata[sswd_pkg::STAT_ERR_BIT])
      err_reg <= 1'b0;
  end

  // traffic permissions follow the state being entered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comm_reg <= '0; // see [R09]
    else if (ce)
    begin
      comm_reg.mbx_en   <= state_next != sswd_pkg::ST_INIT; // see [R12]
      comm_reg.foe_only <= state_next == sswd_pkg::ST_BOOT; // see [R18]
      comm_reg.pd_en    <= state_next == sswd_pkg::ST_SAFEOP ||
                           state_next == sswd_pkg::ST_OP; // see [R14] see [R17]
    end
  end

  // ----------------------------------------------------------------
  // process data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_img_reg <= '0;
    else if (ce && (state_next == sswd_pkg::ST_SAFEOP || state_next == sswd_pkg::ST_OP))
      in_img_reg <= din; // see [R13] see [R14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (out_wr)
      begin
        out_reg       <= pwdata[OUT_W-1:0];
        out_valid_reg <= 1'b1;
      end
      else if (sm_trip)
      begin
        out_reg       <= '0; // see [R06]
        out_valid_reg <= 1'b0;
      end
      else if (state_next != sswd_pkg::ST_SAFEOP && state_next != sswd_pkg::ST_OP)
        out_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout_reg <= '0;
    else if (ce)
    begin
      if (state_reg == sswd_pkg::ST_OP) // see [R17]
        dout_reg <= out_reg;
      else if (state_reg == sswd_pkg::ST_SAFEOP && wd_cfg_reg.sm_time == 16'h0000) // see [R15]
        dout_reg <= out_reg;
      else
        dout_reg <= '0; // see [R14]
    end
  end

  // ----------------------------------------------------------------
  // shared watchdog tick
  // ----------------------------------------------------------------
  // 40 ns base ticks from the 25 ns clock by phase accumulation
  assign acc_sum   = {1'b0, acc_reg} + sswd_pkg::CLK_PERIOD_NS;
  assign base_tick = acc_sum >= sswd_pkg::BASE_TICK_NS;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg     <= 6'h00;
      presc_reg   <= 17'h00000;
      wd_tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      acc_reg     <= base_tick ? 6'(acc_sum - sswd_pkg::BASE_TICK_NS) : acc_sum[5:0];
      wd_tick_reg <= 1'b0;
      if (base_tick)
      begin
        if (presc_reg + 17'h00001 >= {1'b0, wd_cfg_reg.mult} + sswd_pkg::MULT_EXTRA) // see [R02]
        begin
          presc_reg   <= 17'h00000;
          wd_tick_reg <= 1'b1; // see [R01]
        end
        else
          presc_reg <= presc_reg + 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdogs
  // ----------------------------------------------------------------
  sswd_wd_counter #(.W(16)) u_sm_wd (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (wd_tick_reg),
    .reload  (out_wr),
    .run     (out_valid_reg && pd_state),
    .limit   (wd_cfg_reg.sm_time),
    .expired (sm_exp)
  );

  sswd_wd_counter #(.W(16)) u_pdi_wd (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (wd_tick_reg),
    .reload  (pdi_kick),
    .run     (1'b1),
    .limit   (wd_cfg_reg.pdi_time),
    .expired (pdi_exp)
  );

  assign sm_trip  = sm_exp && !sm_exp_q;
  assign pdi_trip = pdi_exp && !pdi_exp_q;

  // sticky trip flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sm_exp_q    <= 1'b0;
      pdi_exp_q   <= 1'b0;
      wd_stat_reg <= 2'h0;
    end
    else if (ce)
    begin
      sm_exp_q  <= sm_exp;
      pdi_exp_q <= pdi_exp;
      for (int i = 0; i < 2; i++)
      begin
        if ((i == sswd_pkg::WD_SM_BIT) ? sm_trip : pdi_trip)
          wd_stat_reg[i] <= 1'b1;
        else if (wr_en && paddr == sswd_pkg::OFS_WD_STAT && pwdata[i])
          wd_stat_reg[i] <= 1'b0;
      end
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign dout          = dout_reg;
  assign comm          = comm_reg;
  assign sm_wd_tripped = wd_stat_reg[sswd_pkg::WD_SM_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [16:0] hlp_bt_reg;
  logic        hlp_ok_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hlp_bt_reg <= 17'h00000;
      hlp_ok_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_en && paddr == sswd_pkg::OFS_MULT)
        hlp_ok_reg <= 1'b0;
      else if (wd_tick_reg)
        hlp_ok_reg <= 1'b1;
      if (wd_tick_reg)
        hlp_bt_reg <= 17'(base_tick);
      else if (base_tick)
        hlp_bt_reg <= hlp_bt_reg + 17'h00001;
    end
  end

  property p_tick_len;
    ce && base_tick && hlp_ok_reg && !wd_tick_reg &&
      hlp_bt_reg + 17'h00001 == {1'b0, wd_cfg_reg.mult} + sswd_pkg::MULT_EXTRA |=> wd_tick_reg;
  endproperty
  a_tick_len: assert property (p_tick_len) else $error("tick length wrong"); // see [R02]

  property p_mult_nonzero;
    wd_cfg_reg.mult != 16'h0000;
  endproperty
  a_mult_nonzero: assert property (p_mult_nonzero) else $error("multiplier zero"); // see [R05]

  property p_init_blocked;
    state_reg == sswd_pkg::ST_INIT |-> !comm_reg.mbx_en && !comm_reg.pd_en;
  endproperty
  a_init_blocked: assert property (p_init_blocked) else $error("traffic in init"); // see [R09]

  property p_preop_gate;
    ce && state_reg == sswd_pkg::ST_INIT && !cfg_reg[sswd_pkg::CFG_MBX_BIT]
      |=> state_reg != sswd_pkg::ST_PREOP;
  endproperty
  a_preop_gate: assert property (p_preop_gate) else $error("preop without mailbox"); // see [R11]

  property p_boot_entry;
    state_reg != sswd_pkg::ST_INIT && state_reg != sswd_pkg::ST_BOOT
      |=> state_reg != sswd_pkg::ST_BOOT;
  endproperty
  a_boot_entry: assert property (p_boot_entry) else $error("boot not from init"); // see [R18]

  property p_safeop_safe;
    ce && state_reg == sswd_pkg::ST_SAFEOP && wd_cfg_reg.sm_time != 16'h0000
      |=> dout_reg == '0;
  endproperty
  a_safeop_safe: assert property (p_safeop_safe) else $error("outputs set in safeop"); // see [R14]

  property p_op_drive;
    ce && state_reg == sswd_pkg::ST_OP |=> dout_reg == $past(out_reg);
  endproperty
  a_op_drive: assert property (p_op_drive) else $error("op outputs wrong"); // see [R17]

  property p_trip_clear;
    ce && sm_trip && !out_wr |=> out_reg == '0 ##1 (!ce || !$past(ce) || dout_reg == '0);
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("outputs kept after trip"); // see [R06]

  property p_wd_off;
    ce && wd_cfg_reg.sm_time == 16'h0000 |=> !sm_exp;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired"); // see [R07]

  property p_reload;
    ce && out_wr && wd_cfg_reg.sm_time != 16'h0001 |=> !sm_exp [*2];
  endproperty
  a_reload: assert property (p_reload) else $error("expiry right after write"); // see [R20]

endmodule

`default_nettype wire

/* File: tb/sswd_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sswd_master_model (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h000,
  output logic [31:0]      pwdata  = 32'h00000000,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // one transfer, request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_sswd_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_sswd_top;
  logic                 pclk     = 1'b0;
  logic                 presetn  = 1'b0;
  logic                 ce       = 1'b1;
  logic                 pdi_kick = 1'b0;
  logic [15:0]          din      = 16'h0000;
  logic                 psel, penable, pwrite, pready, pslverr, tripped;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rdat, v;
  logic                 rerr;
  logic [15:0]          dout;
  sswd_pkg::sswd_comm_t comm;
  int                   seed = 19682;
  int                   err_total = 0;
  int                   compares = 0;
  int                   cycles = 0;
  int                   codes[3] = '{0, 5, 15};

  always #12.5 pclk = ~pclk;

  sswd_top #(.OUT_W(16)) u_sswd_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .pdi_kick(pdi_kick), .dout(dout),
    .comm(comm), .sm_wd_tripped(tripped));

  sswd_master_model u_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int wd_cyc(input int m, input int lim);
    return lim * (m + 2) * 8 / 5;
  endfunction

  task automatic final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_master.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    u_master.xfer(1'b0, a, 32'h00000000, rdat, rerr);
    check("apb read", rdat & m, e);
  endtask

  task automatic go(input logic [3:0] c, input logic [31:0] e);
    wr(12'h120, {28'h0000000, c});
    rd(12'h130, 32'h0000001f, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5)
    begin
      @(posedge pclk);
      pdi_kick <= 1'($random(seed));
    end
    presetn <= 1'b1;
    pdi_kick <= 1'b0;
    rd(12'h400, 32'h0000ffff, 32'h000009c2);
    rd(12'h420, 32'h0000ffff, 32'h000003e8);
    rd(12'h130, 32'h0000001f, 32'h00000001);
    check("comm init", {29'h0, comm}, 32'h00000000);
    wr(12'h400, 32'h00000000);
    rd(12'h400, 32'h0000ffff, 32'h000009c2);
    wr(12'h420, 32'h0000ffff);
    rd(12'h420, 32'h0000ffff, 32'h0000ffff);
    rd(12'h7fc, 32'hffffffff, 32'h00000000);
    check("slverr", {31'h0, rerr}, 32'h00000001);
    go(4'h2, 32'h00000011);
    wr(12'h140, 32'h00000001);
    go(4'h2, 32'h00000012);
    check("comm preop", {29'h0, comm}, 32'h00000004);
    go(4'h3, 32'h00000012);
    wr(12'h130, 32'h00000010);
    go(4'h1, 32'h00000001);
    go(4'h3, 32'h00000003);
    check("comm boot", {30'h0, comm.foe_only, comm.pd_en}, 32'h00000002);
    go(4'h1, 32'h00000001);
    go(4'h2, 32'h00000002);
    wr(12'h140, 32'h00000007);
    go(4'h4, 32'h00000004);
    check("comm safeop", {29'h0, comm}, 32'h00000005);
    v = $random(seed);
    din <= v[15:0];
    cyc(3);
    rd(12'hf80, 32'h0000ffff, {16'h0000, v[15:0]});
    wr(12'h400, 32'h00000001);
    wr(12'h410, 32'h00000008);
    // reload the local-side watchdog with its short time
    pdi_kick <= 1'b1;
    cyc(1);
    pdi_kick <= 1'b0;
    v = $random(seed) & 32'h0000ffff;
    wr(12'hf00, v);
    cyc(3);
    check("dout safeop", {16'h0, dout}, 32'h00000000);
    go(4'h8, 32'h00000008);
    cyc(3);
    check("dout op", {16'h0, dout}, v);
    foreach (codes[i])
      go(codes[i][3:0], 32'h00000018);
    wr(12'h420, 32'h00000008);
    repeat (4)
    begin
      v = $random(seed) & 32'h0000ffff;
      wr(12'hf00, v);
      cyc(20);
      check("dout kept", {16'h0, dout}, v);
    end
    cyc(wd_cyc(1, 7) - 23);
    check("dout before trip", {16'h0, dout}, v);
    cyc(13);
    check("dout after trip", {16'h0, dout}, 32'h00000000);
    check("trip flag", {31'h0, tripped}, 32'h00000001);
    rd(12'h440, 32'h00000003, 32'h00000003);
    wr(12'h440, 32'h00000003);
    wr(12'h420, 32'h00000000);
    go(4'h4, 32'h00000014);
    v = $random(seed) & 32'h0000ffff;
    wr(12'hf00, v);
    cyc(60);
    check("dout wd off", {16'h0, dout}, v);
    rd(12'h440, 32'h00000001, 32'h00000000);
    final_report();
  end
endmodule

`default_nettype wire
